// file: hw/gtm_consts.vh
// Purpose: register map, field positions and reset values of the timer
// Assumes: included by the timer design, its checker and the testbench
// Notes: definitions only
`ifndef GTM_CONSTS_VH
`define GTM_CONSTS_VH
// -----------------------------------------------------------------
// register word offsets (byte addresses)
// -----------------------------------------------------------------
`define GTM_ADR_CFG 8'h00
`define GTM_ADR_LO_MODE 8'h04
`define GTM_ADR_HI_MODE 8'h08
`define GTM_ADR_CTL 8'h0C
`define GTM_ADR_IMR 8'h18
`define GTM_ADR_RIS 8'h1C
`define GTM_ADR_MIS 8'h20
`define GTM_ADR_ICR 8'h24
`define GTM_ADR_LO_ILR 8'h28
`define GTM_ADR_HI_ILR 8'h2C
`define GTM_ADR_LO_MATCH 8'h30
`define GTM_ADR_LO_PR 8'h38
`define GTM_ADR_HI_PR 8'h3C
`define GTM_ADR_LO_CNT 8'h48
`define GTM_ADR_HI_CNT 8'h4C
// -----------------------------------------------------------------
// configuration values
// -----------------------------------------------------------------
`define GTM_CFG_32 3'h0
`define GTM_CFG_RTC 3'h1
`define GTM_CFG_16 3'h4
// mode field values
`define GTM_MODE_ONESHOT 2'h1
`define GTM_MODE_PERIODIC 2'h2
// -----------------------------------------------------------------
// control bit positions
// -----------------------------------------------------------------
`define GTM_CTL_LO_EN 0
`define GTM_CTL_LO_STALL 1
`define GTM_CTL_RTC_OVR 4
`define GTM_CTL_LO_OTE 5
`define GTM_CTL_HI_EN 8
`define GTM_CTL_HI_STALL 9
`define GTM_CTL_HI_OTE 13
// status / mask / clear bit positions
`define GTM_IRQ_LO_TO 0
`define GTM_IRQ_RTC 3
`define GTM_IRQ_HI_TO 8
// -----------------------------------------------------------------
// reset values and divider
// -----------------------------------------------------------------
`define GTM_RST_CNT 16'hFFFF
`define GTM_RST_ILR 16'hFFFF
`define GTM_RST_PR 8'h00
`define GTM_RTC_DIV_EDGES 32768
`endif

// file: hw/gtm_dual_timer.v
// Purpose: dual 16-bit timer joinable to a 32-bit timer or 32-bit clock
// Assumes: classic Wishbone slave, one 20 MHz clock, async high reset
// Notes: 16-bit capture and PWM modes are not part of this block
// Notes on behaviour
// - two 16-bit halves, or one 32-bit unit
// - own trigger ORed with chained block triggers
// - pinless block ignores its clock pin
// - reset: inactive, counts/loads 0xFFFF, prescales zero
// - config 0 timer, config 1 clock
// - 32-bit modes act as single timer
// - low load write fills both halves
// - low count read returns both halves
// - low mode field alone picks one-shot/periodic
// - enabled counter counts down, reloads after zero
// - one-shot stops, clears enable; periodic continues
// - zero sets sticky time-out flag until cleared
// - masked time-out follows raw when unmasked
// - one-clock trigger when counter reaches zero
// - load write during run taken next cycle, except in clock mode
// - stall bit plus stall signal freezes count
// - clock mode counts up, first load one
// - match rolls counter to zero, keeps counting
// - match sets clock flags; clear bit clears
// - clock override ignores stall bits
// - config 4 gives two independent halves
//
// Design decisions made here: the placing of the registers and register access over Wishbone.
`include "gtm_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module gtm_dual_timer #(
   parameter HAS_PINS = 1,
   parameter RTC_DIVIDE = `GTM_RTC_DIV_EDGES
)(
   // clock and reset
   input wire clk,
   input wire rst,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // pins and chip-level signals
   input wire capturePin0,
   input wire debugStall,
   input wire trigChainIn,
   output reg adcTrigger,
   output reg timerIrq
);
   // -----------------------------------------------------------------
   // byte-lane merge, used by every writable register
   // -----------------------------------------------------------------
   // keeps old lanes where sel is low; callers pass zero as old
   function [31:0] laneMerge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] sel;
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1)
            laneMerge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   reg [2:0] cfgSel; // config_select_reg
   reg [3:0] loModeReg; // low_half_mode_reg
   reg [3:0] hiModeReg; // high_half_mode_reg
   reg [15:0] ctlReg; // control_reg
   reg [15:0] imrReg; // irq_mask_reg
   reg [15:0] risReg; // raw_irq_status_reg
   reg [15:0] loIlr; // low_interval_load_reg
   reg [15:0] hiIlr; // high_interval_load_reg
   reg [15:0] loMatch; // low half of 32-bit match
   reg [15:0] hiMatch; // high half of 32-bit match
   reg [7:0] loPr; // low_prescale_reg, stored only
   reg [7:0] hiPr; // high_prescale_reg, stored only
   reg [15:0] loCnt; // low_half_counter
   reg [15:0] hiCnt; // high_half_counter
   reg rtcLoaded; // clock mode seen once
   reg [15:0] divCnt; // 1 Hz divider
   reg rtcTick; // one-cycle divided tick
   reg pinMeta; // synchroniser stage 1
   reg pinSync; // synchroniser stage 2
   reg pinLast; // edge history of stage 2

   // -----------------------------------------------------------------
   // decode
   // -----------------------------------------------------------------
   // a request is cyc and stb together; ack qualifies the write
   // so a write lands once, at the edge where the master sees ack
   wire busReq = wb_cyc_i & wb_stb_i;
   wire wrNow = busReq & wb_we_i & wb_ack_o; // write lands on ack edge
   wire is32 = (cfgSel == `GTM_CFG_32) | (cfgSel == `GTM_CFG_RTC);
   wire isRtc = (cfgSel == `GTM_CFG_RTC);
   wire is16 = (cfgSel == `GTM_CFG_16);
   // joined views: the high half is always the upper word
   wire [31:0] cnt32 = {hiCnt, loCnt};
   wire [31:0] ilr32 = {hiIlr, loIlr};
   wire [31:0] match32 = {hiMatch, loMatch};
   // unselected byte lanes are written as zero
   wire [31:0] wrData = laneMerge(32'h0000_0000, wb_dat_i, wb_sel_i);
   wire loEn = ctlReg[`GTM_CTL_LO_EN];
   wire hiEn = ctlReg[`GTM_CTL_HI_EN];
   // stall: stall bit and debug signal both needed
   wire loFrz = ctlReg[`GTM_CTL_LO_STALL] & debugStall;
   wire hiFrz = ctlReg[`GTM_CTL_HI_STALL] & debugStall;
   // clock override ignores both stall bits
   wire rtcFrz = (loFrz | hiFrz) & ~ctlReg[`GTM_CTL_RTC_OVR];
   // 32-bit timer runs off low enable and low mode only
   wire run32 = (cfgSel == `GTM_CFG_32) & loEn & ~loFrz;
   wire runRtc = isRtc & loEn & rtcTick & ~rtcFrz;
   wire runLo = is16 & loEn & ~loFrz;
   wire runHi = is16 & hiEn & ~hiFrz;
   // reaching zero is the step from one to zero
   wire hit32 = run32 & (cnt32 == 32'h0000_0001);
   wire hitLo = runLo & (loCnt == 16'h0001);
   wire hitHi = runHi & (hiCnt == 16'h0001);
   wire hitRtc = runRtc & (cnt32 == match32);
   // any other mode code runs like periodic and never stops
   wire loOneShot = (loModeReg[1:0] == `GTM_MODE_ONESHOT);
   wire hiOneShot = (hiModeReg[1:0] == `GTM_MODE_ONESHOT);
   wire [15:0] icrBits = wrNow && wb_adr_i == `GTM_ADR_ICR ?
      wrData[15:0] : 16'h0000;
   // new raw events placed at their status bit positions
   wire [15:0] setBits = {7'h00, hitHi, 4'h0, hitRtc, 2'h0, hit32 | hitLo};
   wire [15:0] nextRis = (risReg & ~icrBits) | setBits;
   // last divider state; a divide above 65536 needs a wider divCnt
   wire [31:0] divEnd = RTC_DIVIDE - 1;

   // -----------------------------------------------------------------
   // clock pin: two flops, then rising-edge detect on stage 2
   // -----------------------------------------------------------------
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pinMeta <= 1'b0;
         pinSync <= 1'b0;
         pinLast <= 1'b0;
      end
      else
      begin
         // pinless block sees a quiet pin
         pinMeta <= (HAS_PINS != 0) ? capturePin0 : 1'b0;
         pinSync <= pinMeta;
         // edge history reads stage 2 only, never the raw pin
         pinLast <= pinSync;
      end
   end

   // -----------------------------------------------------------------
   // divider: one tick per RTC_DIVIDE rising edges
   // -----------------------------------------------------------------
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         divCnt <= 16'h0000;
         rtcTick <= 1'b0;
      end
      else
      begin
         rtcTick <= 1'b0;
         // divider held clear outside clock mode so ticks start fresh
         if (!isRtc || !loEn)
            divCnt <= 16'h0000;
         // only rising edges of the synchronised pin count
         else if (pinSync & ~pinLast)
         begin
            if ({16'h0000, divCnt} == divEnd)
            begin
               divCnt <= 16'h0000;
               rtcTick <= 1'b1;
            end
            else
               divCnt <= divCnt + 16'h0001;
         end
      end
   end

   // -----------------------------------------------------------------
   // wishbone handshake and read data
   // -----------------------------------------------------------------
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         // ack one cycle after the request, dropped the next cycle
         wb_ack_o <= busReq & ~wb_ack_o;
         // read data latched with the ack, valid while ack stands
         if (busReq & ~wb_ack_o & ~wb_we_i)
         begin
            case (wb_adr_i)
               `GTM_ADR_CFG: wb_dat_o <= {29'h0, cfgSel};
               `GTM_ADR_LO_MODE: wb_dat_o <= {28'h0, loModeReg};
               `GTM_ADR_HI_MODE: wb_dat_o <= {28'h0, hiModeReg};
               `GTM_ADR_CTL: wb_dat_o <= {16'h0, ctlReg};
               `GTM_ADR_IMR: wb_dat_o <= {16'h0, imrReg};
               `GTM_ADR_RIS: wb_dat_o <= {16'h0, risReg};
               // masked view follows raw whenever unmasked
               `GTM_ADR_MIS: wb_dat_o <= {16'h0, risReg & imrReg};
               `GTM_ADR_LO_ILR: wb_dat_o <= is32 ? ilr32 : {16'h0, loIlr};
               `GTM_ADR_HI_ILR: wb_dat_o <= {16'h0, hiIlr};
               `GTM_ADR_LO_MATCH:
                  wb_dat_o <= is32 ? match32 : {16'h0, loMatch};
               `GTM_ADR_LO_PR: wb_dat_o <= {24'h0, loPr};
               `GTM_ADR_HI_PR: wb_dat_o <= {24'h0, hiPr};
               // joined read: high half above low half
               `GTM_ADR_LO_CNT:
                  wb_dat_o <= is32 ? cnt32 : {16'h0, loCnt};
               `GTM_ADR_HI_CNT: wb_dat_o <= {16'h0, hiCnt};
               default: wb_dat_o <= 32'h0000_0000; // unmapped reads zero
            endcase
         end
      end
   end

   // -----------------------------------------------------------------
   // registers, counters and flags; software writes win over hardware
   // except on flags, where a set beats a clear
   // -----------------------------------------------------------------
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         // inactive after reset
         cfgSel <= 3'h0;
         loModeReg <= 4'h0;
         hiModeReg <= 4'h0;
         ctlReg <= 16'h0000;
         imrReg <= 16'h0000;
         risReg <= 16'h0000;
         loIlr <= `GTM_RST_ILR;
         hiIlr <= `GTM_RST_ILR;
         // match all ones: no early roll before software sets it
         loMatch <= 16'hFFFF;
         hiMatch <= 16'hFFFF;
         loPr <= `GTM_RST_PR;
         hiPr <= `GTM_RST_PR;
         loCnt <= `GTM_RST_CNT;
         hiCnt <= `GTM_RST_CNT;
         // the next clock-mode entry counts as the first again
         rtcLoaded <= 1'b0;
         adcTrigger <= 1'b0;
         timerIrq <= 1'b0;
      end
      else
      begin
         // -------- counting --------
         // one count path at a time; split halves idle in joined modes
         // because their run terms need the 16-bit configuration
         if (run32)
         begin
            // zero stays one cycle, then reload
            if (cnt32 == 32'h0000_0000)
            begin
               {hiCnt, loCnt} <= ilr32;
               if (loOneShot)
                  ctlReg[`GTM_CTL_LO_EN] <= 1'b0;
            end
            else
               {hiCnt, loCnt} <= cnt32 - 32'h0000_0001;
         end
         else if (runRtc)
         begin
            // up-count, roll to zero at match
            if (hitRtc)
               {hiCnt, loCnt} <= 32'h0000_0000;
            else
               {hiCnt, loCnt} <= cnt32 + 32'h0000_0001;
         end
         else
         begin
            // independent halves in 16-bit configuration
            if (runLo)
            begin
               if (loCnt == 16'h0000)
               begin
                  loCnt <= loIlr;
                  if (loOneShot)
                     ctlReg[`GTM_CTL_LO_EN] <= 1'b0;
               end
               else
                  loCnt <= loCnt - 16'h0001;
            end
            if (runHi)
            begin
               if (hiCnt == 16'h0000)
               begin
                  hiCnt <= hiIlr;
                  if (hiOneShot)
                     ctlReg[`GTM_CTL_HI_EN] <= 1'b0;
               end
               else
                  hiCnt <= hiCnt - 16'h0001;
            end
         end

         // -------- flags and outputs --------
         // a set in the clear cycle survives, so no event is lost
         // to a clear that arrives late
         risReg <= nextRis;
         timerIrq <= |(nextRis & imrReg);
         // trigger flop rises with the count reaching zero
         adcTrigger <= trigChainIn |
            (hit32 & ctlReg[`GTM_CTL_LO_OTE]) |
            (hitLo & ctlReg[`GTM_CTL_LO_OTE]) |
            (hitHi & ctlReg[`GTM_CTL_HI_OTE]);

         // -------- software writes --------
         if (wrNow)
         begin
            case (wb_adr_i)
               `GTM_ADR_CFG:
               begin
                  cfgSel <= wrData[2:0];
                  // first entry to clock mode preloads one
                  if (wrData[2:0] == `GTM_CFG_RTC && !rtcLoaded)
                  begin
                     {hiCnt, loCnt} <= 32'h0000_0001;
                     rtcLoaded <= 1'b1;
                  end
               end
               `GTM_ADR_LO_MODE: loModeReg <= wrData[3:0];
               `GTM_ADR_HI_MODE: hiModeReg <= wrData[3:0];
               // a control write overrides a self-cleared enable
               `GTM_ADR_CTL: ctlReg <= wrData[15:0];
               `GTM_ADR_IMR: imrReg <= wrData[15:0];
               `GTM_ADR_LO_ILR:
               begin
                  loIlr <= wrData[15:0];
                  if (is32)
                     hiIlr <= wrData[31:16];
                  // counter follows a new load, even mid-run, except in clock mode
                  if (!isRtc)
                  begin
                     loCnt <= wrData[15:0];
                     if (is32)
                        hiCnt <= wrData[31:16];
                  end
               end
               // high load only restarts the high half in split use
               `GTM_ADR_HI_ILR:
               begin
                  hiIlr <= wrData[15:0];
                  if (is16)
                     hiCnt <= wrData[15:0];
               end
               `GTM_ADR_LO_MATCH:
               begin
                  // clock mode takes its match value from here only
                  loMatch <= wrData[15:0];
                  if (is32)
                     hiMatch <= wrData[31:16];
               end
               `GTM_ADR_LO_PR: loPr <= wrData[7:0];
               `GTM_ADR_HI_PR: hiPr <= wrData[7:0];
               default: ; // read-only or unmapped: ignored
            endcase
         end
      end
   end
endmodule // gtm_dual_timer
`default_nettype wire

// file: tb/gtm_chk.sv
// Purpose: port-level assertions for the dual timer
// Assumes: one clock, async active-high reset
// Notes: bound into gtm_dual_timer below
`timescale 1ns/100ps
`default_nettype none
`include "gtm_consts.vh"
module gtm_chk (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // bus side
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // chip side
   input wire logic trigChainIn,
   input wire logic adcTrigger,
   input wire logic timerIrq
);
   // -----------------------------------------------------------------
   // bus handshake
   // -----------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // a fresh request, then a one-cycle answer
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
   property p_ackAns; s_req |=> s_ans; endproperty
   a_ackAns: assert property (p_ackAns) else $error("ack missing");
   property p_ackCause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
   a_ackCause: assert property (p_ackCause) else $error("ack unasked");
   property p_ackOnce; wb_ack_o |=> !wb_ack_o; endproperty
   a_ackOnce: assert property (p_ackOnce) else $error("ack too long");
   // -----------------------------------------------------------------
   // reset, trigger and interrupt
   // -----------------------------------------------------------------
   property p_rstQuiet;
      $fell(rst) |-> !wb_ack_o && !adcTrigger && !timerIrq;
   endproperty
   a_rstQuiet: assert property (p_rstQuiet)
      else $error("busy at reset");
   property p_chainPass; trigChainIn |=> adcTrigger; endproperty
   a_chainPass: assert property (p_chainPass)
      else $error("chain lost");
   // own pulse never stretches past one clock
   property p_trigOne;
      adcTrigger && !$past(trigChainIn) |=> !adcTrigger || $past(trigChainIn);
   endproperty
   a_trigOne: assert property (p_trigOne)
      else $error("trigger long");
   // masked status read agrees with the interrupt line
   property p_irqMirror;
      wb_ack_o && !wb_we_i && wb_adr_i == `GTM_ADR_MIS
         |-> (|wb_dat_o) == $past(timerIrq);
   endproperty
   a_irqMirror: assert property (p_irqMirror)
      else $error("mis vs irq");
   // flags are sticky: only a software write lowers the line
   // a clear write lands on the edge of the fall, a mask write one edge before it
   property p_irqFall;
      $fell(timerIrq) |->
         $past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2);
   endproperty
   a_irqFall: assert property (p_irqFall)
      else $error("irq dropped");
endmodule // gtm_chk
bind gtm_dual_timer gtm_chk gtm_chk_i (.clk(clk), .rst(rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .trigChainIn(trigChainIn), .adcTrigger(adcTrigger), .timerIrq(timerIrq));
`default_nettype wire

// file: tb/gtm_pin_src.sv
// Purpose: slow clock source on the even capture pin
// Assumes: free phase against the system clock
// Notes: pin rests low while not running
`timescale 1ns/100ps
`default_nettype none
module gtm_pin_src #(
   parameter real HALF_NS = 15258.8
) (
   // control
   input wire logic run,
   // pin
   output logic pin
);
   // -----------------------------------------------------------------
   // 32.768 kHz toggle, still outside use
   // -----------------------------------------------------------------
   initial pin = 1'b0;
   always
   begin
      #(HALF_NS);
      pin = run ? ~pin : 1'b0;
   end
endmodule // gtm_pin_src
`default_nettype wire

// file: tb/testbench.sv
// Purpose: self-checking bench for the dual timer
// Assumes: 20 MHz clock, small clock divider of 4
// Notes: one task per scenario
`timescale 1ns/100ps
`default_nettype none
`include "gtm_consts.vh"
module testbench;
   // -----------------------------------------------------------------
   // signals
   // -----------------------------------------------------------------
   logic clk, rst, wb_cyc_i, wb_stb_i, wb_we_i;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, rd, held;
   wire logic [31:0] wb_dat_o;
   wire logic wb_ack_o, adcTrigger, timerIrq, capturePin0;
   logic debugStall, trigChainIn, pinRun;
   int err_total, check_count, n;
   gtm_dual_timer #(.HAS_PINS(1), .RTC_DIVIDE(4)) gtm_dual_timer_i (
      .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .capturePin0(capturePin0), .debugStall(debugStall),
      .trigChainIn(trigChainIn), .adcTrigger(adcTrigger), .timerIrq(timerIrq));
   gtm_pin_src gtm_pin_src_i (.run(pinRun), .pin(capturePin0));
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // -----------------------------------------------------------------
   // shared tasks
   // -----------------------------------------------------------------
   task results;
      if (err_total == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one classic cycle; holds until ack, takes data at that edge
   task wbGo(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int k;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 10);
      if (k >= 10)
      begin
         err_total++;
         results;
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task wr(input logic [7:0] adr, input logic [31:0] dat);
      wbGo(1'b1, adr, dat);
   endtask
   task rdc(input string what, input logic [7:0] adr, input logic [31:0] exp);
      wbGo(1'b0, adr, 32'h00000000);
      chk(what, rd, exp);
   endtask
   // wait for a trigger, then it must be gone one clock later
   task waitTrig;
      n = 0;
      while (adcTrigger !== 1'b1 && n < 300)
      begin
         @(posedge clk);
         n++;
      end
      chk("trigger seen", {31'h0, n < 300}, 32'h1);
      if (n >= 300)
         results;
      @(posedge clk);
      chk("trigger one clock", {31'h0, adcTrigger}, 32'h0);
   endtask
   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task scReset;
      rdc("lo count", `GTM_ADR_LO_CNT, 32'hFFFFFFFF);
      rdc("hi count", `GTM_ADR_HI_CNT, 32'h0000FFFF);
      rdc("hi load", `GTM_ADR_HI_ILR, 32'h0000FFFF);
      rdc("lo load", `GTM_ADR_LO_ILR, 32'hFFFFFFFF);
      rdc("lo prescale", `GTM_ADR_LO_PR, 32'h00000000);
      rdc("hi prescale", `GTM_ADR_HI_PR, 32'h00000000);
      rdc("control", `GTM_ADR_CTL, 32'h00000000);
      wr(8'h40, 32'hFFFFFFFF);
      rdc("unmapped", 8'h40, 32'h00000000);
   endtask
   task scOneShot;
      wr(`GTM_ADR_CFG, 32'h0);
      wr(`GTM_ADR_LO_MODE, 32'h1);
      wr(`GTM_ADR_LO_ILR, 32'h00030004);
      rdc("hi load split", `GTM_ADR_HI_ILR, 32'h00000003);
      rdc("count pair", `GTM_ADR_LO_CNT, 32'h00030004);
      wr(`GTM_ADR_IMR, 32'h1);
      wr(`GTM_ADR_LO_ILR, 32'h6);
      wr(`GTM_ADR_CTL, 32'h21);
      waitTrig;
      rdc("enable cleared", `GTM_ADR_CTL, 32'h20);
      rdc("reloaded", `GTM_ADR_LO_CNT, 32'h6);
      rdc("raw timeout", `GTM_ADR_RIS, 32'h1);
      chk("irq line", {31'h0, timerIrq}, 32'h1);
      rdc("masked timeout", `GTM_ADR_MIS, 32'h1);
      wr(`GTM_ADR_ICR, 32'h1);
      rdc("raw cleared", `GTM_ADR_RIS, 32'h0);
   endtask
   task scPeriodic;
      wr(`GTM_ADR_HI_MODE, 32'h1);
      wr(`GTM_ADR_LO_MODE, 32'h2);
      wr(`GTM_ADR_LO_ILR, 32'h3);
      wr(`GTM_ADR_CTL, 32'h21);
      waitTrig;
      waitTrig;
      wr(`GTM_ADR_LO_ILR, 32'h100);
      wbGo(1'b0, `GTM_ADR_LO_CNT, 32'h0);
      chk("new load", {31'h0, rd > 32'hF0 && rd <= 32'h100}, 32'h1);
      wr(`GTM_ADR_CTL, 32'h23);
      debugStall <= 1'b1;
      wbGo(1'b0, `GTM_ADR_LO_CNT, 32'h0);
      held = rd;
      rdc("stalled", `GTM_ADR_LO_CNT, held);
      debugStall <= 1'b0;
      wbGo(1'b0, `GTM_ADR_LO_CNT, 32'h0);
      chk("resumed", {31'h0, rd < held}, 32'h1);
      wr(`GTM_ADR_CTL, 32'h0);
      wr(`GTM_ADR_ICR, 32'h109);
   endtask
   task scRtc;
      wr(`GTM_ADR_CFG, 32'h1);
      rdc("first load", `GTM_ADR_LO_CNT, 32'h1);
      wr(`GTM_ADR_LO_MATCH, 32'h2);
      wr(`GTM_ADR_IMR, 32'h8);
      wr(`GTM_ADR_CTL, 32'h13);
      debugStall <= 1'b1;
      pinRun <= 1'b1;
      n = 0;
      while (timerIrq !== 1'b1 && n < 20000)
      begin
         @(posedge clk);
         n++;
      end
      held = {31'h0, n >= 4270 && n <= 4890};
      chk("tick time", held, 32'h1);
      if (n >= 20000)
         results;
      rdc("rolled", `GTM_ADR_LO_CNT, 32'h0);
      rdc("clock raw", `GTM_ADR_RIS, 32'h8);
      wr(`GTM_ADR_ICR, 32'h8);
      rdc("clock masked", `GTM_ADR_MIS, 32'h0);
      pinRun <= 1'b0;
      debugStall <= 1'b0;
      wr(`GTM_ADR_CTL, 32'h0);
   endtask
   task scSplit;
      wr(`GTM_ADR_CFG, 32'h4);
      wr(`GTM_ADR_HI_MODE, 32'h2);
      wr(`GTM_ADR_HI_ILR, 32'h3);
      wr(`GTM_ADR_CTL, 32'h2100);
      waitTrig;
      wr(`GTM_ADR_CTL, 32'h0);
      rdc("high raw", `GTM_ADR_RIS, 32'h100);
      trigChainIn <= 1'b1;
      @(posedge clk);
      trigChainIn <= 1'b0;
      @(posedge clk);
      chk("chained trigger", {31'h0, adcTrigger}, 32'h1);
   endtask
   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial
   begin
      rst = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, debugStall, trigChainIn, pinRun} = 6'h00;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h00000000;
      err_total = 0;
      check_count = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      scReset;
      scOneShot;
      scPeriodic;
      scRtc;
      scSplit;
      results;
   end
endmodule // testbench
`default_nettype wire
